// [sbe_exec.v]
`timescale 1ns/1ps
// Function
// - Decrement-skip subtracts one, flags untouched
// - Destination bit picks accumulator or register
// - Decrement zero result skips next instruction
// - Increment-skip adds one, flags untouched
// - Increment zero result skips next instruction
// - Jump loads 11-bit immediate into PC
// - Latch bits 4:3 go to PC 12:11
// - Jump takes two cycles, flags untouched
`include "sbe_consts.vh"

module sbe_exec (
  input  wire                      clk,
  input  wire                      sys_rst,
  input  wire                      instr_valid,
  input  wire [`SBE_OPC_W-1:0]     instr_op,
  input  wire [`SBE_FADDR_W-1:0]   instr_faddr,
  input  wire                      instr_dest,
  input  wire [`SBE_JIMM_W-1:0]    instr_imm,
  input  wire [`SBE_DATA_W-1:0]    freg_rdata,
  input  wire [`SBE_DATA_W-1:0]    pc_high_latch,
  output reg                       acc_we_ff,
  output reg  [`SBE_DATA_W-1:0]    acc_wdata_ff,
  output reg                       freg_we_ff,
  output reg  [`SBE_FADDR_W-1:0]   freg_waddr_ff,
  output reg  [`SBE_DATA_W-1:0]    freg_wdata_ff,
  output reg                       pc_load_ff,
  output reg  [`SBE_PC_W-1:0]      pc_target_ff,
  output reg                       squash_ff,
  output reg                       flags_we_ff
);

  // ----------------------------------------
  // Slot states
  // ----------------------------------------
  localparam ST_RUN  = 2'b01;
  localparam ST_NOP  = 2'b10;

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function sbe_is_skip;
    input [`SBE_OPC_W-1:0] op;
    begin
      sbe_is_skip = (op == `SBE_OPC_DECSKIP) || (op == `SBE_OPC_INCSKIP);
    end
  endfunction

  function sbe_is_jump;
    input [`SBE_OPC_W-1:0] op;
    begin
      sbe_is_jump = (op == `SBE_OPC_JUMP);
    end
  endfunction

  function sbe_is_zero;
    input [`SBE_DATA_W-1:0] value;
    begin
      sbe_is_zero = (value == `SBE_ZERO);
    end
  endfunction

  function [`SBE_DATA_W-1:0] sbe_step;
    input [`SBE_OPC_W-1:0]  op;
    input [`SBE_DATA_W-1:0] value;
    begin
      case (op)
        `SBE_OPC_DECSKIP: sbe_step = value - `SBE_ONE;
        `SBE_OPC_INCSKIP: sbe_step = value + `SBE_ONE;
        default:          sbe_step = value;
      endcase
    end
  endfunction

  function [`SBE_PC_W-1:0] sbe_jump_target;
    input [`SBE_DATA_W-1:0] latch;
    input [`SBE_JIMM_W-1:0] imm;
    begin
      sbe_jump_target = {latch[`SBE_PCL_HI:`SBE_PCL_LO], imm};
    end
  endfunction

  // ----------------------------------------
  // Internal signals
  // ----------------------------------------
  reg  [1:0]                state_ff;
  reg  [1:0]                nxt_state;
  reg                       nxt_acc_we;
  reg  [`SBE_DATA_W-1:0]    nxt_acc_wdata;
  reg                       nxt_freg_we;
  reg  [`SBE_FADDR_W-1:0]   nxt_freg_waddr;
  reg  [`SBE_DATA_W-1:0]    nxt_freg_wdata;
  reg                       nxt_pc_load;
  reg  [`SBE_PC_W-1:0]      nxt_pc_target;
  reg                       nxt_squash;
  reg                       nxt_flags_we;
  wire [`SBE_DATA_W-1:0]    result;
  wire                      exec_ok;
  wire                      is_skip;
  wire                      is_jump;
  wire                      skip_taken;

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  // Follower in the no-operation slot never executes
  assign exec_ok    = instr_valid && (state_ff == ST_RUN);
  assign is_skip    = exec_ok && sbe_is_skip(instr_op);
  assign is_jump    = exec_ok && sbe_is_jump(instr_op);
  assign result     = sbe_step(instr_op, freg_rdata);
  assign skip_taken = is_skip && sbe_is_zero(result);

  // ----------------------------------------
  // Slot sequencing
  // ----------------------------------------
  always @* begin
    case (state_ff)
      ST_RUN: begin
        if (skip_taken || is_jump) begin
          nxt_state = ST_NOP;
        end else begin
          nxt_state = ST_RUN;
        end
      end
      ST_NOP: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // Next output values
  // ----------------------------------------
  always @* begin
    nxt_acc_we     = is_skip && (instr_dest == `SBE_DEST_W);
    nxt_acc_wdata  = result;
    nxt_freg_we    = is_skip && (instr_dest == `SBE_DEST_F);
    nxt_freg_waddr = instr_faddr;
    nxt_freg_wdata = result;
    nxt_pc_load    = is_jump;
    nxt_pc_target  = sbe_jump_target(pc_high_latch, instr_imm);
    nxt_squash     = (nxt_state == ST_NOP);
    nxt_flags_we   = `SBE_BIT_OFF;
  end

  // ----------------------------------------
  // Slot state register
  // ----------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Accumulator write port
  // ----------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_we_ff <= `SBE_BIT_OFF;
    end else begin
      acc_we_ff <= nxt_acc_we;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_wdata_ff <= `SBE_ZERO;
    end else begin
      acc_wdata_ff <= nxt_acc_wdata;
    end
  end

  // ----------------------------------------
  // Register file write port
  // ----------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      freg_we_ff <= `SBE_BIT_OFF;
    end else begin
      freg_we_ff <= nxt_freg_we;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      freg_waddr_ff <= `SBE_ADDR_RST;
    end else begin
      freg_waddr_ff <= nxt_freg_waddr;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      freg_wdata_ff <= `SBE_ZERO;
    end else begin
      freg_wdata_ff <= nxt_freg_wdata;
    end
  end

  // ----------------------------------------
  // Program counter load
  // ----------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_load_ff <= `SBE_BIT_OFF;
    end else begin
      pc_load_ff <= nxt_pc_load;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_target_ff <= `SBE_PC_RST;
    end else begin
      pc_target_ff <= nxt_pc_target;
    end
  end

  // ----------------------------------------
  // Slot and flag strobes
  // ----------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      squash_ff <= `SBE_BIT_OFF;
    end else begin
      squash_ff <= nxt_squash;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_we_ff <= `SBE_BIT_OFF;
    end else begin
      flags_we_ff <= nxt_flags_we;
    end
  end

endmodule // sbe_exec

// [sbe_consts.vh]
`ifndef SBE_CONSTS_VH
`define SBE_CONSTS_VH
// ----------------------------------------
// Instruction field layout
// ----------------------------------------
`define SBE_OPC_W        3
`define SBE_OPC_NONE     3'h0
`define SBE_OPC_DECSKIP  3'h1
`define SBE_OPC_INCSKIP  3'h2
`define SBE_OPC_JUMP     3'h3
`define SBE_FADDR_W      7
`define SBE_DATA_W       8
`define SBE_JIMM_W       11
`define SBE_PC_W         13
`define SBE_PCL_HI       4
`define SBE_PCL_LO       3
`define SBE_DEST_W       1'h0
`define SBE_DEST_F       1'h1
`define SBE_ONE          8'h01
`define SBE_ZERO         8'h00
`define SBE_PC_RST       13'h0000
`define SBE_ADDR_RST     7'h00
`define SBE_BIT_OFF      1'b0
`endif

// [sbe_props.sv]
`timescale 1ns/1ps
module sbe_props(input wire clk,sys_rst,instr_valid,instr_dest,acc_we_ff,freg_we_ff,pc_load_ff,
  squash_ff,flags_we_ff,input wire [2:0] instr_op,input wire [10:0] instr_imm,
  input wire [7:0] freg_rdata,pc_high_latch,acc_wdata_ff,freg_wdata_ff,
  input wire [12:0] pc_target_ff);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire        t = instr_valid && !squash_ff;
  wire [2:0]  o = instr_op;
  wire [7:0]  w = freg_we_ff ? freg_wdata_ff : acc_wdata_ff;
  wire [12:0] g = {pc_high_latch[4:3], instr_imm};
  AST_DEC: assert property(t&&o==1 |=> w==$past(freg_rdata)-8'h01) else $error("dec");
  AST_INC: assert property(t&&o==2 |=> w==$past(freg_rdata)+8'h01) else $error("inc");
  AST_DST: assert property(t&&o inside{1,2} |=> freg_we_ff==$past(instr_dest)&&acc_we_ff!=freg_we_ff) else $error("dst");
  AST_DSK: assert property(t&&o==1 |=> squash_ff==(w==0)) else $error("dsk");
  AST_ISK: assert property(t&&o==2 |=> squash_ff==(w==0)) else $error("isk");
  AST_JMP: assert property(t&&o==3 |=> pc_load_ff&&pc_target_ff==$past(g)) else $error("jmp");
  AST_JTW: assert property(t&&o==3 |=> squash_ff&&!flags_we_ff ##1 !squash_ff) else $error("jtw");
  AST_NOP: assert property(squash_ff |=> !(acc_we_ff||freg_we_ff||pc_load_ff)) else $error("nop");
  AST_C_DSK: cover property(t&&o==1 ##1 squash_ff);
  AST_C_ISK: cover property(t&&o==2 ##1 squash_ff);
  AST_C_JMP: cover property(pc_load_ff);
endmodule // sbe_props
bind sbe_exec sbe_props u_props(.*);

// [sbe_rf.sv]
`timescale 1ns/1ps
module sbe_rf(input wire clk,we,input wire [6:0] ra,wa,input wire [7:0] wd,output wire [7:0] rd);
  reg [7:0] m[0:127];
  integer   k;
  initial for (k = 0; k < 128; k = k + 1) m[k] = k[7:0] - 8'h01;
  assign rd = m[ra];
  always @(posedge clk) if (we) m[wa] <= wd;
endmodule // sbe_rf

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(a,b) begin checks++; if ((a)!==(b)) begin fails++; $display("ERROR %0t %h %h",$time,a,b); end end
module testbench;
  reg clk=0,sys_rst=1,instr_valid=0,instr_dest=0,sq=0,pw=0,v,d;
  reg [2:0] instr_op=0; reg [6:0] instr_faddr=0,pa; reg [10:0] instr_imm=0,i;
  reg [7:0] pc_high_latch=0,mir[0:127],r,pv,l; reg [1:0] o,a; reg [17:0] q[$],e;
  wire [7:0] freg_rdata,acc_wdata_ff,freg_wdata_ff; wire [6:0] freg_waddr_ff;
  wire [12:0] pc_target_ff; wire acc_we_ff,freg_we_ff,pc_load_ff,squash_ff,flags_we_ff;
  wire [17:0] got = {squash_ff,freg_we_ff,acc_we_ff,pc_load_ff ? {2'h0,pc_target_ff} :
    {freg_waddr_ff,freg_we_ff ? freg_wdata_ff : acc_wdata_ff}};
  integer seed=25408,fails=0,checks=0,k,n;
  initial forever #5 clk = ~clk;
  sbe_exec dut(.*);
  sbe_rf rf(.clk(clk),.we(freg_we_ff),.ra(instr_faddr),.wa(freg_waddr_ff),.wd(freg_wdata_ff),
    .rd(freg_rdata));
  task give_verdict; begin
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  end endtask
  always @(negedge clk) if (acc_we_ff|freg_we_ff|pc_load_ff) begin
    `CHK(flags_we_ff,1'b0)
    `CHK(q.size()!=0,1'b1)
    e = (q.size() != 0) ? q.pop_front() : 18'h0;
    `CHK(got,e)
  end
  initial begin
    for (k = 0; k < 128; k++) mir[k] = k[7:0] - 8'h01;
    repeat (10) @(posedge clk);
    sys_rst <= 0;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      v=$random(seed); o=$random(seed); a=$random(seed); d=$random(seed); i=$random(seed); l=$random(seed);
      instr_valid <= v; instr_op <= {1'b0,o}; instr_faddr <= {5'h0,a}; instr_dest <= d;
      instr_imm <= i; pc_high_latch <= l;
      r = (o == 1) ? mir[a] - 8'h01 : mir[a] + 8'h01;
      if (pw) mir[pa] = pv;
      pw = 0;
      if (v && !sq && o != 0) begin
        q.push_back(o == 3 ? {3'b100,2'h0,l[4:3],i} : {r == 8'h00,d,!d,5'h0,a,r});
        pw = d && o != 3; pa = {5'h0,a}; pv = r; sq = (o == 3) || (r == 8'h00);
      end else sq = 0;
    end
    @(posedge clk);
    instr_valid <= 0;
    repeat (3) @(posedge clk);
    `CHK(q.size()==0,1'b1)
    $display("random run done");
    give_verdict;
  end
endmodule // testbench
